// [stxps_pkg.sv]
// Constants, types and helpers of the serial transmit input and pin select.
// Assumes one 40 MHz clock, twice the crystal reference rate.
//
// Overview of operation
// - Code 45 puts the pin 0 drive-enable flag out; low means pin 0 is input.
// - Code 0x2F drives low; invert bit set turns it into a constant high.
// - Codes 0x30-0x3F give crystal clock divisions; only one pin carries one.
// - Pin 0 selector resets to crystal clock divided by 192.
// - Packet format 3 is asynchronous mode with pin 0 as data input.
// - Asynchronous mode bypasses packet hardware and FIFO, sending the pin level.
// - Asynchronous mode applies no whitening, interleaving, error coding or Manchester.
// - Minimum-shift keying is not offered in asynchronous mode.
// - Asynchronous input is sampled at eight times the programmed data rate.
// - Packet format 1 is synchronous mode with device bit clock and pin 0 data.
// - Device outputs a bit clock; host presents each bit in step with it.
// - In synchronous mode pin 0 turns input while transmission is active.
// - Synchronous data leaves eight bit periods after it is sampled.
// - Sync mode field decides whether preamble and sync are inserted.
// - With insertion the device prepends preamble and sync; host gives payload.
// - With invert clear, data is sampled on the bit clock's rising edge.

package stxps_pkg;

	// ---------------------------------------------------------------
	// Bus geometry and register indices.
	// ---------------------------------------------------------------
	localparam int AW = 12;
	localparam int DW = 32;
	localparam logic [9:0] IDX_PIN1_CFG = 10'h001;
	localparam logic [9:0] IDX_PIN0_CFG = 10'h002;
	localparam logic [9:0] IDX_PKT_CTRL = 10'h008;
	localparam logic [9:0] IDX_MOD_CFG_A = 10'h011;
	localparam logic [9:0] IDX_MOD_CFG_B = 10'h012;
	localparam logic [9:0] IDX_STB_TX_ON = 10'h035;
	localparam logic [9:0] IDX_STB_IDLE = 10'h036;
	localparam logic [9:0] IDX_RATE = 10'h040;
	localparam logic [9:0] IDX_STATUS = 10'h041;
	localparam logic [9:0] IDX_SYNC_WORD = 10'h042;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ---------------------------------------------------------------
	// Field positions.
	// ---------------------------------------------------------------
	localparam int PKT_FMT_LSB = 0;
	localparam int PKT_WHITEN_BIT = 6;
	localparam int MODA_SYNC_LSB = 0;
	localparam int MODB_MANCH_BIT = 3;
	localparam int MODB_FMT_LSB = 4;
	localparam int MODB_FEC_BIT = 7;

	// ---------------------------------------------------------------
	// Types.
	// ---------------------------------------------------------------
	typedef struct packed {
		logic inv;
		logic [5:0] sel;
	} stxps_pin_cfg_s;

	typedef enum logic [1:0] {
		FMT_FIFO = 2'b00,
		FMT_SYNC = 2'b01,
		FMT_RSVD = 2'b10,
		FMT_ASYNC = 2'b11
	} stxps_fmt_e;

	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_HDR = 2'b01,
		PH_DATA = 2'b10
	} stxps_phase_e;

	// ---------------------------------------------------------------
	// Selector codes, modulation codes and reset values.
	// ---------------------------------------------------------------
	localparam logic [5:0] SEL_SCLK = 6'h0B;
	localparam logic [5:0] SEL_NRDY = 6'h29;
	localparam logic [5:0] SEL_OSC = 6'h2B;
	localparam logic [5:0] SEL_DIR = 6'h2D;
	localparam logic [5:0] SEL_HIZ = 6'h2E;
	localparam logic [5:0] SEL_LOW = 6'h2F;
	localparam logic [5:0] SEL_CLK_BASE = 6'h30;
	localparam logic [5:0] SEL_CLK192 = 6'h3F;
	localparam logic [2:0] MOD_2FSK = 3'h0;
	localparam logic [2:0] MOD_MSK = 3'h7;
	localparam stxps_pin_cfg_s PIN0_RST = '{inv: 1'b0, sel: SEL_CLK192};
	localparam stxps_pin_cfg_s PIN1_RST = '{inv: 1'b0, sel: SEL_HIZ};
	localparam logic [2:0] SYNC_MODE_RST = 3'h2;
	localparam logic [15:0] RATE_RST = 16'h0032;
	localparam logic [15:0] SYNC_WORD_RST = 16'h5A0F;

	// ---------------------------------------------------------------
	// Serial timing counts.
	// ---------------------------------------------------------------
	localparam logic [2:0] PHASE_LAST = 3'h7;
	localparam int DELAY_BITS = 8;
	localparam logic [5:0] PRE_BITS = 6'h20;
	localparam logic [5:0] HDR_LAST = 6'h2F;

	// Returns the divided clock period in CLK cycles for a clock code.
	function automatic logic [8:0] div_period(input logic [3:0] i);
		logic [8:0] p;
		p = 9'h002;
		unique case (i)
			4'h0: p = 9'h002;
			4'h1: p = 9'h003;
			4'h2: p = 9'h004;
			4'h3: p = 9'h006;
			4'h4: p = 9'h008;
			4'h5: p = 9'h00C;
			4'h6: p = 9'h010;
			4'h7: p = 9'h018;
			4'h8: p = 9'h020;
			4'h9: p = 9'h030;
			4'hA: p = 9'h040;
			4'hB: p = 9'h060;
			4'hC: p = 9'h080;
			4'hD: p = 9'h0C0;
			4'hE: p = 9'h100;
			4'hF: p = 9'h180;
		endcase
		return p;
	endfunction

endpackage

// [stxps_top.sv]
// Serial transmit data input, bit timing and general output pin selector.
// Assumes an AXI4-Lite master, an analog oscillator flag and a modulator.
//
// Added by the designer: the AXI4-Lite register port and the address map.

module stxps_top
	import stxps_pkg::*;
(
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic [AW-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [DW-1:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [AW-1:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [DW-1:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic PIN0_IN,
	output logic PIN0_OUT,
	output logic PIN0_OE_N,
	output logic PIN1_OUT,
	output logic PIN1_OE_N,
	input wire logic OSC_STABLE_IN,
	output logic TX_ACTIVE,
	output logic TX_BIT,
	output logic TX_BIT_STB,
	output logic [2:0] MOD_FORMAT,
	output logic CODING_EN,
	output logic FIFO_PATH_EN
);

	// ---------------------------------------------------------------
	// Storage.
	// ---------------------------------------------------------------
	logic pin0_m_q, pin0_s_q, osc_m_q, osc_s_q;
	logic aw_hold_q, w_hold_q;
	logic [AW-1:0] aw_addr_q;
	logic [DW-1:0] w_data_q;
	logic [3:0] w_strb_q;
	stxps_pin_cfg_s pin0_q, pin1_q;
	stxps_fmt_e fmt_q;
	logic whiten_q, manch_q, fec_q, tx_active_q;
	logic [2:0] sync_mode_q, mod_fmt_q;
	logic [15:0] rate_q, sync_word_q, samp_cnt_q;
	logic [2:0] phase_q;
	stxps_phase_e ph_q, ph_d;
	logic [5:0] hdr_idx_q;
	logic [DELAY_BITS-1:0] delay_q;
	logic sclk_q;
	logic [8:0] div_cnt_q;
	logic clk_lvl_q;
	logic first_q;

	// True for a word-aligned address that a register answers.
	function automatic logic addr_mapped(input logic [AW-1:0] a);
		logic [9:0] i;
		i = a[AW-1:2];
		return (a[1:0] == 2'b00) && (i == IDX_PIN1_CFG ||
			i == IDX_PIN0_CFG || i == IDX_PKT_CTRL ||
			i == IDX_MOD_CFG_A || i == IDX_MOD_CFG_B ||
			i == IDX_STB_TX_ON || i == IDX_STB_IDLE ||
			i == IDX_RATE || i == IDX_STATUS || i == IDX_SYNC_WORD);
	endfunction

	// ---------------------------------------------------------------
	// Bus handshake decode.
	// ---------------------------------------------------------------
	wire aw_fire = S_AXI_AWVALID & S_AXI_AWREADY;
	wire w_fire = S_AXI_WVALID & S_AXI_WREADY;
	wire b_fire = S_AXI_BVALID & S_AXI_BREADY;
	wire ar_fire = S_AXI_ARVALID & S_AXI_ARREADY;
	wire r_fire = S_AXI_RVALID & S_AXI_RREADY;
	wire wr_go = aw_hold_q & w_hold_q & ~S_AXI_BVALID;
	wire [9:0] wr_idx = aw_addr_q[AW-1:2];
	wire wr_ok = wr_go & addr_mapped(aw_addr_q);
	wire b0 = w_strb_q[0];
	wire b1 = w_strb_q[1];
	wire we_pin1 = wr_ok & b0 & (wr_idx == IDX_PIN1_CFG);
	wire we_pin0 = wr_ok & b0 & (wr_idx == IDX_PIN0_CFG);
	wire we_pkt = wr_ok & b0 & (wr_idx == IDX_PKT_CTRL);
	wire we_moda = wr_ok & b0 & (wr_idx == IDX_MOD_CFG_A);
	wire we_modb = wr_ok & b0 & (wr_idx == IDX_MOD_CFG_B);
	wire st_on = wr_ok & b0 & (wr_idx == IDX_STB_TX_ON);
	wire st_idle = wr_ok & b0 & (wr_idx == IDX_STB_IDLE);
	wire we_rate = wr_ok & (wr_idx == IDX_RATE);
	wire we_sync = wr_ok & (wr_idx == IDX_SYNC_WORD);

	// ---------------------------------------------------------------
	// Operating mode decode.
	// ---------------------------------------------------------------
	wire is_async = (fmt_q == FMT_ASYNC);
	wire is_sync = (fmt_q == FMT_SYNC);
	wire run = tx_active_q & (is_async | is_sync);
	wire pin0_input = is_async | (is_sync & tx_active_q);
	wire pin0_drive_enable_low = ~pin0_input;
	wire [15:0] rate_eff = (rate_q == 16'h0000) ? 16'h0001 : rate_q;
	wire samp_stb = run & (samp_cnt_q == rate_eff - 16'h0001);
	wire bit_stb = samp_stb & (phase_q == PHASE_LAST);
	wire [2:0] phase_d = samp_stb ? phase_q + 3'h1 : phase_q;
	wire hdr_bit = (hdr_idx_q < PRE_BITS) ? ~hdr_idx_q[0] :
		sync_word_q[4'(HDR_LAST - hdr_idx_q)];

	// Status and read data selection.
	wire [9:0] rd_idx = S_AXI_ARADDR[AW-1:2];
	wire [7:0] status = {3'h0, ph_q, pin0_input, ~osc_s_q, tx_active_q};
	wire [15:0] rd_val =
		(rd_idx == IDX_PIN1_CFG) ? {9'h000, pin1_q} :
		(rd_idx == IDX_PIN0_CFG) ? {9'h000, pin0_q} :
		(rd_idx == IDX_PKT_CTRL) ? {9'h000, whiten_q, 4'h0, fmt_q} :
		(rd_idx == IDX_MOD_CFG_A) ? {13'h0000, sync_mode_q} :
		(rd_idx == IDX_MOD_CFG_B) ? {8'h00, fec_q, mod_fmt_q, manch_q,
			3'h0} :
		(rd_idx == IDX_RATE) ? rate_q :
		(rd_idx == IDX_STATUS) ? {osc_s_q, 7'h00, status} :
		(rd_idx == IDX_SYNC_WORD) ? sync_word_q : 16'h0000;
	wire rd_ok = addr_mapped(S_AXI_ARADDR);

	// ---------------------------------------------------------------
	// Pin selector.
	// ---------------------------------------------------------------
	wire pin0_clk = (pin0_q.sel >= SEL_CLK_BASE);
	wire pin1_clk = (pin1_q.sel >= SEL_CLK_BASE);
	wire [8:0] div_per = div_period(pin0_clk ? pin0_q.sel[3:0] :
		pin1_q.sel[3:0]);
	wire div_on = pin0_clk | pin1_clk;

	// Level a selector code routes to a pin before inversion.
	function automatic logic pin_mux(input logic [5:0] sel,
		input logic clk_ok);
		logic v;
		v = 1'b0;
		if (sel >= SEL_CLK_BASE)
			v = clk_ok & clk_lvl_q;
		else if (sel == SEL_SCLK)
			v = sclk_q;
		else if (sel == SEL_NRDY)
			v = ~osc_s_q;
		else if (sel == SEL_OSC)
			v = osc_s_q;
		else if (sel == SEL_DIR)
			v = pin0_drive_enable_low;
		else
			v = 1'b0;
		return v;
	endfunction

	// Inversion follows the selector on each pin.
	wire pin0_lvl = pin_mux(pin0_q.sel, 1'b1) ^ pin0_q.inv;
	wire pin1_lvl = pin_mux(pin1_q.sel, ~pin0_clk) ^ pin1_q.inv;

	// Header phase sequencing for synchronous mode.
	always_comb
	begin
		ph_d = ph_q;
		unique case (ph_q)
			PH_IDLE: if (run & is_sync)
				ph_d = (sync_mode_q != 3'h0) ? PH_HDR : PH_DATA;
			PH_HDR: if (!run)
				ph_d = PH_IDLE;
			else if (bit_stb && hdr_idx_q == HDR_LAST)
				ph_d = PH_DATA;
			PH_DATA: if (!run)
				ph_d = PH_IDLE;
			default: ph_d = PH_IDLE;
		endcase
	end

	// Input synchronisers for the data pin and oscillator flag.
	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
			{pin0_m_q, pin0_s_q, osc_m_q, osc_s_q} <= 4'h0;
		else
			{pin0_m_q, pin0_s_q, osc_m_q, osc_s_q} <=
				{PIN0_IN, pin0_m_q, OSC_STABLE_IN, osc_m_q};
	end

	// Bus slave: address and data in either order, one answer each.
	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			{aw_hold_q, w_hold_q, S_AXI_BVALID, S_AXI_RVALID} <= 4'h0;
			{S_AXI_AWREADY, S_AXI_WREADY, S_AXI_ARREADY} <= 3'h7;
			aw_addr_q <= '0;
			w_data_q <= '0;
			w_strb_q <= 4'h0;
			S_AXI_BRESP <= RESP_OKAY;
			S_AXI_RRESP <= RESP_OKAY;
			S_AXI_RDATA <= '0;
		end
		else
		begin
			if (aw_fire)
			begin
				aw_addr_q <= S_AXI_AWADDR;
				aw_hold_q <= 1'b1;
				S_AXI_AWREADY <= 1'b0;
			end
			if (w_fire)
			begin
				w_data_q <= S_AXI_WDATA;
				w_strb_q <= S_AXI_WSTRB;
				w_hold_q <= 1'b1;
				S_AXI_WREADY <= 1'b0;
			end
			if (wr_go)
			begin
				{aw_hold_q, w_hold_q} <= 2'b00;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end
			if (b_fire)
			begin
				S_AXI_BVALID <= 1'b0;
				{S_AXI_AWREADY, S_AXI_WREADY} <= 2'b11;
			end
			if (ar_fire)
			begin
				S_AXI_ARREADY <= 1'b0;
				S_AXI_RVALID <= 1'b1;
				S_AXI_RDATA <= {16'h0000, rd_ok ? rd_val : 16'h0000};
				S_AXI_RRESP <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			end
			if (r_fire)
			begin
				S_AXI_RVALID <= 1'b0;
				S_AXI_ARREADY <= 1'b1;
			end
		end
	end

	// Configuration registers and transmit strobes.
	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			pin0_q <= PIN0_RST;
			pin1_q <= PIN1_RST;
			fmt_q <= FMT_FIFO;
			{whiten_q, manch_q, fec_q, tx_active_q} <= 4'h0;
			sync_mode_q <= SYNC_MODE_RST;
			mod_fmt_q <= MOD_2FSK;
			rate_q <= RATE_RST;
			sync_word_q <= SYNC_WORD_RST;
		end
		else
		begin
			if (we_pin0)
				pin0_q <= stxps_pin_cfg_s'(w_data_q[6:0]);
			if (we_pin1)
				pin1_q <= stxps_pin_cfg_s'(w_data_q[6:0]);
			if (we_pkt)
			begin
				fmt_q <= stxps_fmt_e'(w_data_q[PKT_FMT_LSB +: 2]);
				whiten_q <= w_data_q[PKT_WHITEN_BIT];
			end
			if (we_moda)
				sync_mode_q <= w_data_q[MODA_SYNC_LSB +: 3];
			if (we_modb)
			begin
				mod_fmt_q <= w_data_q[MODB_FMT_LSB +: 3];
				manch_q <= w_data_q[MODB_MANCH_BIT];
				fec_q <= w_data_q[MODB_FEC_BIT];
			end
			if (we_rate & b0)
				rate_q[7:0] <= w_data_q[7:0];
			if (we_rate & b1)
				rate_q[15:8] <= w_data_q[15:8];
			if (we_sync & b0)
				sync_word_q[7:0] <= w_data_q[7:0];
			if (we_sync & b1)
				sync_word_q[15:8] <= w_data_q[15:8];
			if (st_on)
				tx_active_q <= 1'b1;
			else if (st_idle)
				tx_active_q <= 1'b0;
		end
	end

	// Oversampling counter, bit phase and header position.
	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			samp_cnt_q <= 16'h0000;
			phase_q <= 3'h0;
			ph_q <= PH_IDLE;
			hdr_idx_q <= 6'h00;
			sclk_q <= 1'b0;
		end
		else
		begin
			samp_cnt_q <= (!run || samp_stb) ? 16'h0000 :
				samp_cnt_q + 16'h0001;
			phase_q <= run ? phase_d : 3'h0;
			ph_q <= ph_d;
			hdr_idx_q <= (ph_q != PH_HDR) ? 6'h00 :
				bit_stb ? hdr_idx_q + 6'h01 : hdr_idx_q;
			// The clock only rises where a payload bit is taken.
			sclk_q <= (ph_q == PH_DATA) & (ph_d == PH_DATA) &
				(bit_stb | (sclk_q & ~phase_d[2]));
		end
	end

	// Transmit bit path: pin level in asynchronous mode, header or delayed bits else.
	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			delay_q <= '0;
			TX_BIT <= 1'b0;
			TX_BIT_STB <= 1'b0;
		end
		else
		begin
			TX_BIT_STB <= is_async ? samp_stb : (bit_stb & ph_q != PH_IDLE);
			if (is_async & samp_stb)
				TX_BIT <= pin0_s_q;
			else if (ph_q == PH_HDR & bit_stb)
				TX_BIT <= hdr_bit;
			else if (ph_q == PH_DATA & bit_stb)
			begin
				delay_q <= {delay_q[DELAY_BITS-2:0], pin0_s_q};
				TX_BIT <= delay_q[DELAY_BITS-1];
			end
			if (ph_q == PH_IDLE)
				delay_q <= '0;
		end
	end

	// Shared divided clock and registered pin and modulator outputs.
	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			div_cnt_q <= 9'h000;
			clk_lvl_q <= 1'b0;
			{PIN0_OUT, PIN1_OUT, PIN0_OE_N, PIN1_OE_N} <= 4'h0;
			{TX_ACTIVE, CODING_EN, FIFO_PATH_EN} <= 3'h0;
			MOD_FORMAT <= MOD_2FSK;
			first_q <= 1'b1;
		end
		else
		begin
			div_cnt_q <= (!div_on || div_cnt_q >= div_per - 9'h001) ?
				9'h000 : div_cnt_q + 9'h001;
			clk_lvl_q <= div_on & (div_cnt_q < {1'b0, div_per[8:1]});
			PIN0_OUT <= pin0_lvl;
			PIN1_OUT <= pin1_lvl;
			PIN0_OE_N <= pin0_input | (pin0_q.sel == SEL_HIZ);
			PIN1_OE_N <= (pin1_q.sel == SEL_HIZ);
			TX_ACTIVE <= tx_active_q;
			CODING_EN <= ~is_async & (whiten_q | manch_q | fec_q);
			FIFO_PATH_EN <= (fmt_q == FMT_FIFO);
			MOD_FORMAT <= (is_async && mod_fmt_q == MOD_MSK) ?
				MOD_2FSK : mod_fmt_q;
			first_q <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Assertions.
	// ---------------------------------------------------------------
	default clocking dc @(posedge CLK); endclocking
	default disable iff (!RSTN);

	a_reset_default: assert property (first_q |-> pin0_q.sel == SEL_CLK192)
		else $error("pin 0 selector did not reset to divide by 192");
	a_dir_flag: assert property ((pin1_q.sel == SEL_DIR && !pin1_q.inv) |=>
		PIN1_OUT == !$past(pin0_input))
		else $error("direction flag wrong on pin 1");
	a_low_code: assert property (pin1_q.sel == SEL_LOW |=>
		PIN1_OUT == $past(pin1_q.inv))
		else $error("fixed level code wrong");
	a_one_clock: assert property ((pin0_clk && pin1_clk && !pin1_q.inv) |=>
		!PIN1_OUT)
		else $error("two divided clocks on the pins");
	a_reserved_low: assert property (pin1_q.sel == 6'h24 |=>
		PIN1_OUT == $past(pin1_q.inv))
		else $error("reserved code not inactive");
	a_async_input: assert property (is_async |=> PIN0_OE_N && !FIFO_PATH_EN)
		else $error("pin 0 not input in asynchronous mode");
	a_async_coding: assert property (is_async |=> !CODING_EN)
		else $error("coding enabled in asynchronous mode");
	a_async_msk: assert property (is_async |=> MOD_FORMAT != MOD_MSK)
		else $error("minimum-shift keying offered in asynchronous mode");
	a_async_sample: assert property ((is_async && samp_stb) |=>
		TX_BIT == $past(pin0_s_q) && TX_BIT_STB)
		else $error("asynchronous sample not passed on");
	a_sync_input: assert property ((is_sync && tx_active_q) |=> PIN0_OE_N)
		else $error("pin 0 not input during synchronous transmit");
	a_sync_latency: assert property ((ph_q == PH_DATA && bit_stb) |=>
		TX_BIT == $past(delay_q[DELAY_BITS-1]))
		else $error("synchronous bit latency wrong");
	a_hdr_select: assert property ((ph_q == PH_IDLE && run && is_sync &&
		sync_mode_q != 3'h0) |=> ph_q == PH_HDR)
		else $error("header insertion not started");
	a_hdr_quiet: assert property (ph_q == PH_HDR |-> !sclk_q)
		else $error("bit clock runs during header");
	a_rise_sample: assert property ($rose(sclk_q) |-> $past(bit_stb))
		else $error("bit clock rise not at sample point");
	c_async_tx: cover property (is_async && TX_BIT_STB);
	c_sync_payload: cover property (ph_q == PH_DATA && TX_BIT_STB);
	c_div_clock: cover property (pin0_clk && $rose(PIN0_OUT));

endmodule // stxps_top

// [stxps_host.sv]
// Host model that feeds serial transmit data into pin 0.
// Assumes the device bit clock comes back on the pin 1 output.

module stxps_host (
	input wire logic clk,
	input wire logic en,
	input wire logic sync,
	input wire logic level,
	input wire logic bit_clk,
	output logic pin
);
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [15:0] PAT = 16'hC5A3;
	logic clk_q = 1'b0;
	logic [3:0] idx_q = 4'h0;

	initial
		pin = 1'b0;

	// A steady level in async mode, the next NRZ bit after each fall.
	always @(posedge clk)
	begin
		clk_q <= bit_clk;
		if (!en)
			pin <= ~pin; // A released line holds no old value.
		else if (!sync)
		begin
			pin <= level;
			idx_q <= 4'h0;
		end
		else if (clk_q && !bit_clk)
		begin
			idx_q <= idx_q + 4'h1;
			pin <= PAT[idx_q + 4'h1];
		end
	end
endmodule // stxps_host

// [tb.sv]
// Self-checking bench of the serial transmit input and pin selector.
// Assumes the host model on pin 0 and an AXI4-Lite master in this file.

module tb
	import stxps_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ---------------------------------------------------------------
	// Signals and expectations.
	// ---------------------------------------------------------------
	localparam int PER[16] = '{2, 3, 4, 6, 8, 12, 16, 24, 32, 48, 64, 96,
		128, 192, 256, 384};
	localparam logic [6:0] CODE[5] = '{7'h2F, 7'h6F, 7'h24, 7'h29, 7'h2B};
	localparam logic EXP[5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
	logic CLK = 1'b0;
	logic RSTN = 1'b0;
	logic [AW-1:0] awaddr = '0;
	logic [AW-1:0] araddr = '0;
	logic [DW-1:0] wdata = '0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic osc = 1'b0;
	logic level = 1'b0;
	logic hsync = 1'b0;
	logic mon = 1'b0;
	logic clk1_q = 1'b0;
	wire logic awready, wready, bvalid, arready, rvalid, pin0_in, pin0_out;
	wire logic pin0_oe_n, pin1_out, pin1_oe_n, tx_active, tx_bit, tx_stb;
	wire logic coding_en, fifo_en;
	wire logic [1:0] bresp, rresp;
	wire logic [DW-1:0] rdata;
	wire logic [2:0] mod_format;
	logic [31:0] d;
	logic [1:0] r;
	int num_errors = 0;
	int n_tests = 0;
	int rises = 0;
	int p;
	logic q[$];

	always #12.5 CLK = ~CLK;

	stxps_top i_dut (.CLK(CLK), .RSTN(RSTN), .S_AXI_AWADDR(awaddr),
		.S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
		.S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
		.S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
		.S_AXI_RREADY(rready), .PIN0_IN(pin0_in), .PIN0_OUT(pin0_out),
		.PIN0_OE_N(pin0_oe_n), .PIN1_OUT(pin1_out), .PIN1_OE_N(pin1_oe_n),
		.OSC_STABLE_IN(osc), .TX_ACTIVE(tx_active), .TX_BIT(tx_bit),
		.TX_BIT_STB(tx_stb), .MOD_FORMAT(mod_format),
		.CODING_EN(coding_en), .FIFO_PATH_EN(fifo_en));

	stxps_host i_host (.clk(CLK), .en(pin0_oe_n), .sync(hsync),
		.level(level), .bit_clk(pin1_out), .pin(pin0_in));

	// ---------------------------------------------------------------
	// Bus tasks and comparison.
	// ---------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!aw_ok || !w_ok)
		begin
			@(posedge CLK);
			if (!aw_ok && awready)
			begin
				awvalid <= 1'b0;
				aw_ok = 1'b1;
			end
			if (!w_ok && wready)
			begin
				wvalid <= 1'b0;
				w_ok = 1'b1;
			end
		end
		do @(posedge CLK); while (!bvalid);
		r = bresp;
		bready <= 1'b0;
		@(posedge CLK);
	endtask

	task automatic rd(input logic [11:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge CLK); while (!arready);
		arvalid <= 1'b0;
		do @(posedge CLK); while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge CLK);
	endtask

	// Measures one rise-to-rise period of pin 0 in clock cycles.
	task automatic per();
		do @(posedge CLK); while (pin0_out);
		do @(posedge CLK); while (!pin0_out);
		p = 0;
		do
		begin
			@(posedge CLK);
			p++;
		end while (pin0_out);
		do
		begin
			@(posedge CLK);
			p++;
		end while (!pin0_out);
	endtask

	task automatic conclude();
		if (num_errors == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Each data bit must leave eight bit clock periods after it was taken.
	always @(posedge CLK)
	begin
		clk1_q <= pin1_out;
		if (pin1_out && !clk1_q)
		begin
			rises++;
			if (mon)
				q.push_back(pin0_in);
		end
		if (mon && !pin1_out && clk1_q && q.size() > 0)
			chk("tx_bit_delay", q.size() > 8 ? q[q.size() - 9] : 1'b0,
				tx_bit);
	end

	initial
	begin
		#1ms;
		num_errors++;
		conclude();
	end

	// ---------------------------------------------------------------
	// Test sequence.
	// ---------------------------------------------------------------
	initial
	begin
		repeat (2) @(posedge CLK);
		RSTN <= 1'b1;
		repeat (2) @(posedge CLK);
		chk("pin1_oe_n", 32'h1, pin1_oe_n);
		rd(12'h008);
		chk("pin0_cfg", 32'h3F, d);
		rd(12'h004);
		chk("pin1_cfg", 32'h2E, d);
		rd(12'h0FC);
		chk("rd_resp", {30'h0, RESP_SLVERR}, {30'h0, r});
		chk("unmapped", 32'h0, d);
		wr(12'h0FC, 32'h1);
		chk("wr_resp", {30'h0, RESP_SLVERR}, {30'h0, r});
		for (int i = 0; i < 16; i++)
		begin
			wr(12'h008, 32'h30 + i);
			per();
			per();
			chk("div_period", PER[i], p);
		end
		wr(12'h004, 32'h30);
		repeat (3)
		begin
			@(posedge CLK);
			chk("pin1_excl", 32'h0, pin1_out);
		end
		wr(12'h008, 32'h2F);
		chk("wr_resp", {30'h0, RESP_OKAY}, {30'h0, r});
		for (int i = 0; i < 5; i++)
		begin
			wr(12'h004, CODE[i]);
			repeat (2) @(posedge CLK);
			chk("pin1_level", EXP[i], pin1_out);
		end
		osc <= 1'b1;
		repeat (4) @(posedge CLK);
		chk("osc_flag", 32'h1, pin1_out);
		wr(12'h004, 32'h2D);
		chk("dir_flag", 32'h1, pin1_out);
		wr(12'h100, 32'h4);
		wr(12'h048, 32'hF8);
		wr(12'h020, 32'h43);
		repeat (2) @(posedge CLK);
		chk("dir_flag", 32'h1, {pin1_out, pin0_oe_n});
		chk("coding", 32'h0, {coding_en, fifo_en});
		chk("mod_format", 32'h0, mod_format);
		level <= 1'b1;
		wr(12'h0D4, 32'h1);
		chk("tx_active", 32'h1, tx_active);
		do @(posedge CLK); while (!tx_stb);
		p = 0;
		do
		begin
			@(posedge CLK);
			p++;
		end while (!tx_stb);
		chk("sample_gap", 32'h4, p);
		repeat (12) @(posedge CLK);
		chk("tx_bit", 32'h1, tx_bit);
		level <= 1'b0;
		repeat (12) @(posedge CLK);
		chk("tx_bit", 32'h0, tx_bit);
		wr(12'h0D8, 32'h1);
		chk("tx_active", 32'h0, tx_active);
		wr(12'h004, 32'h0B);
		wr(12'h100, 32'h2);
		wr(12'h048, 32'h0);
		wr(12'h044, 32'h0);
		wr(12'h020, 32'h1);
		rises = 0;
		hsync <= 1'b1;
		mon <= 1'b1;
		wr(12'h0D4, 32'h1);
		chk("pin0_oe_n", 32'h1, pin0_oe_n);
		rd(12'h104);
		chk("phase", 32'h2, d[4:3]);
		repeat (384) @(posedge CLK);
		chk("bits_seen", 32'h1, rises > 20);
		mon <= 1'b0;
		wr(12'h0D8, 32'h1);
		chk("pin0_oe_n", 32'h0, pin0_oe_n);
		wr(12'h044, 32'h2);
		rises = 0;
		wr(12'h0D4, 32'h1);
		rd(12'h104);
		chk("phase", 32'h1, d[4:3]);
		do @(posedge CLK); while (!tx_stb);
		chk("preamble", 32'h1, tx_bit);
		do @(posedge CLK); while (!tx_stb);
		chk("preamble", 32'h0, tx_bit);
		repeat (640) @(posedge CLK);
		chk("hdr_clock", 32'h0, rises);
		repeat (200) @(posedge CLK);
		rd(12'h104);
		chk("phase", 32'h2, d[4:3]);
		wr(12'h0D8, 32'h1);
		conclude();
	end
endmodule // tb
